//--- bio_unit.sv
// Bit I/O unit with external codes and load/reset traps behind AXI4-Lite.
`timescale 1ns/1ps
module bio_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic [bio_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bio_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bitSerialInput,
  input wire logic [2:0] interruptCodeInputs,
  output bio_pkg::bio_pins_s addrPins,
  output logic bitOutputStrobe,
  output logic instructionFetchFlag,
  output logic memWriteStrobeN,
  output logic trapStrobe,
  output logic [15:0] trapVector
);
  import bio_pkg::*;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [AXI_AW-1:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic awHeldReg, wHeldReg;
  logic [31:0] cmdReg, cmdNew, rdMux;
  logic [15:0] baseReg, wdataReg, rdataReg, statusWordReg, savedStatusReg;
  logic wrEn, wrOk, cmdStart, rdOk;
  bio_state_e seqReg;
  bio_op_e opReg, opNew;
  logic loadPendReg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    wrEn = awHeldReg && wHeldReg && !s_axi_bvalid;
    cmdNew = merge(cmdReg, wDataReg, wStrbReg);
    opNew = bio_op_e'(cmdNew[CMD_OP_LSB +: 3]);
    cmdStart = wrEn && (awAddrReg == REG_CMD) && (seqReg == SQ_IDLE) && !loadPendReg
               && (opNew != OP_NONE) && (opNew != OP_BAD);
    wrOk = (awAddrReg == REG_BASE) || (awAddrReg == REG_WDATA) || (awAddrReg == REG_STAT)
           || ((awAddrReg == REG_CMD) && (seqReg == SQ_IDLE) && !loadPendReg);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddrReg <= '0;
      wDataReg <= 32'h0;
      wStrbReg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldReg <= 1'b1;
        awAddrReg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
        awHeldReg <= 1'b0;
        wHeldReg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmdReg <= 32'h0;
      baseReg <= 16'h0;
      wdataReg <= 16'h0;
    end else if (wrEn && wrOk) begin
      if (awAddrReg == REG_CMD) begin
        cmdReg <= cmdNew;
      end
      if (awAddrReg == REG_BASE) begin
        baseReg <= 16'(merge({16'h0, baseReg}, wDataReg, wStrbReg));
      end
      if (awAddrReg == REG_WDATA) begin
        wdataReg <= 16'(merge({16'h0, wdataReg}, wDataReg, wStrbReg));
      end
    end
  end

  always_comb begin
    rdOk = 1'b1;
    rdMux = 32'h0;
    unique case (s_axi_araddr)
      REG_CMD: rdMux = cmdReg;
      REG_BASE: rdMux = {16'h0, baseReg};
      REG_WDATA: rdMux = {16'h0, wdataReg};
      REG_RDATA: rdMux = {16'h0, rdataReg};
      REG_STAT: begin
        rdMux = {16'h0, statusWordReg};
        rdMux[STAT_BUSY] = (seqReg != SQ_IDLE);
        rdMux[STAT_HALT] = (seqReg == SQ_HALT);
        rdMux[STAT_RESET] = (seqReg == SQ_RESET);
        rdMux[STAT_LOADPEND] = loadPendReg;
      end
      REG_TRAP: rdMux = {savedStatusReg, trapVector};
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bit sequencer and traps
  // ---------------------------------------------------------------
  logic tick, icReset, icLoad, icIntOk, fieldWideReg, loadPrevReg;
  logic [2:0] extSelReg;
  logic [4:0] remainReg, numBits;
  logic [3:0] idxReg;
  logic [15:0] shiftReg, gatherReg, gatherNow, srcNew;
  logic [10:0] singleAddr;
  bio_code_s extCode;

  bio_tick_div #(.DIV(BIT_PHASE_CYC)) u_div (
    .clk(clk), .srst(srst), .clr(seqReg == SQ_IDLE), .tick(tick)
  );

  bio_ic_decode u_ic (
    .code(interruptCodeInputs), .mask(statusWordReg[3:0]),
    .isReset(icReset), .isLoad(icLoad), .intOk(icIntOk)
  );

  always_comb begin
    numBits = (cmdNew[CMD_CNT_LSB +: 4] == 4'h0) ? 5'd16 : {1'b0, cmdNew[CMD_CNT_LSB +: 4]};
    singleAddr = baseReg[BASE_MSB:BASE_LSB]
                 + {{3{cmdNew[CMD_DISP_LSB + 7]}}, cmdNew[CMD_DISP_LSB +: 8]};
    if (numBits > 5'd8) begin
      srcNew = wdataReg;
    end else begin
      srcNew = {8'h00, cmdNew[CMD_BYTE_POS] ? wdataReg[7:0] : wdataReg[15:8]};
    end
    gatherNow = gatherReg;
    gatherNow[idxReg] = bitSerialInput;
    unique case (bio_ext_e'(cmdNew[CMD_EXT_LSB +: 3]))
      EXT_LOAD_EXEC: extCode = CODE_LOAD_EXEC;
      EXT_CLOCK_OFF: extCode = CODE_CLOCK_OFF;
      EXT_CLOCK_ON: extCode = CODE_CLOCK_ON;
      EXT_RESET: extCode = CODE_RESET;
      default: extCode = CODE_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seqReg <= SQ_RESET;
      opReg <= OP_NONE;
      addrPins <= '0;
      bitOutputStrobe <= 1'b0;
      instructionFetchFlag <= 1'b0;
      memWriteStrobeN <= 1'b1;
      trapStrobe <= 1'b0;
      trapVector <= VEC_RESET_WP;
      statusWordReg <= STW_RESET;
      savedStatusReg <= STW_RESET;
      rdataReg <= 16'h0;
      loadPendReg <= 1'b0;
      loadPrevReg <= 1'b0;
      shiftReg <= 16'h0;
      gatherReg <= 16'h0;
      remainReg <= 5'd0;
      idxReg <= 4'h0;
      fieldWideReg <= 1'b0;
      extSelReg <= 3'h0;
    end else begin
      trapStrobe <= 1'b0;
      instructionFetchFlag <= 1'b0;
      memWriteStrobeN <= 1'b1;
      loadPrevReg <= icLoad;
      if (wrEn && awAddrReg == REG_STAT) begin
        statusWordReg <= 16'(merge({16'h0, statusWordReg}, wDataReg, wStrbReg));
      end
      if (icLoad && !loadPrevReg) begin
        loadPendReg <= 1'b1;
      end
      if (icReset) begin
        seqReg <= SQ_RESET;
        bitOutputStrobe <= 1'b0;
        addrPins.a0 <= 1'b0;
        addrPins.a1 <= 1'b0;
        loadPendReg <= 1'b0;
      end else begin
        unique case (seqReg)
          SQ_RESET: begin
            trapVector <= VEC_RESET_WP;
            statusWordReg <= STW_RESET;
            trapStrobe <= 1'b1;
            seqReg <= SQ_IDLE;
          end
          SQ_IDLE: begin
            if (loadPendReg) begin
              trapVector <= VEC_LOAD;
              savedStatusReg <= statusWordReg;
              statusWordReg[3:0] <= MASK_LOAD;
              trapStrobe <= 1'b1;
              if (!(icLoad && !loadPrevReg)) begin
                loadPendReg <= 1'b0;
              end
            end else if (cmdStart) begin
              opReg <= opNew;
              instructionFetchFlag <= 1'b1;
              extSelReg <= cmdNew[CMD_EXT_LSB +: 3];
              fieldWideReg <= (numBits > 5'd8);
              remainReg <= numBits;
              idxReg <= 4'h0;
              gatherReg <= 16'h0;
              seqReg <= SQ_SETUP;
              addrPins.a0 <= 1'b0;
              addrPins.a1 <= 1'b0;
              if (opNew == OP_FOUT || opNew == OP_FIN) begin
                addrPins.bitAddr <= baseReg[BASE_MSB:BASE_LSB];
                shiftReg <= srcNew;
                addrPins.a13 <= srcNew[0];
              end else if (opNew == OP_EXT) begin
                addrPins.a13 <= extCode.a13;
                addrPins.a0 <= extCode.a0;
                addrPins.a1 <= extCode.a1;
              end else begin
                addrPins.bitAddr <= singleAddr;
                addrPins.a13 <= (opNew == OP_SET1);
              end
            end
          end
          SQ_SETUP: begin
            if (tick) begin
              if (opReg == OP_TEST) begin
                statusWordReg[STW_EQ_POS] <= bitSerialInput;
                seqReg <= SQ_IDLE;
              end else if (opReg == OP_FIN) begin
                gatherReg <= gatherNow;
                if (remainReg > 5'd1) begin
                  addrPins.bitAddr <= addrPins.bitAddr + 11'h1;
                  idxReg <= idxReg + 4'h1;
                  remainReg <= remainReg - 5'd1;
                end else begin
                  if (fieldWideReg) begin
                    rdataReg <= gatherNow;
                  end else if (cmdReg[CMD_BYTE_POS]) begin
                    rdataReg[7:0] <= gatherNow[7:0];
                  end else begin
                    rdataReg[15:8] <= gatherNow[7:0];
                  end
                  memWriteStrobeN <= 1'b0;
                  seqReg <= SQ_IDLE;
                end
              end else begin
                bitOutputStrobe <= 1'b1;
                seqReg <= SQ_STROBE;
              end
            end
          end
          SQ_STROBE: begin
            if (tick) begin
              bitOutputStrobe <= 1'b0;
              if (opReg == OP_FOUT && remainReg > 5'd1) begin
                addrPins.bitAddr <= addrPins.bitAddr + 11'h1;
                shiftReg <= {1'b0, shiftReg[15:1]};
                addrPins.a13 <= shiftReg[1];
                remainReg <= remainReg - 5'd1;
                seqReg <= SQ_SETUP;
              end else if (opReg == OP_EXT && extSelReg == EXT_IDLE) begin
                seqReg <= SQ_HALT;
              end else begin
                addrPins.a0 <= 1'b0;
                addrPins.a1 <= 1'b0;
                seqReg <= SQ_IDLE;
              end
            end
          end
          SQ_HALT: begin
            if (icLoad || icIntOk) begin
              bitOutputStrobe <= 1'b0;
              addrPins.a0 <= 1'b0;
              addrPins.a1 <= 1'b0;
              seqReg <= SQ_IDLE;
            end else if (tick) begin
              bitOutputStrobe <= !bitOutputStrobe;
            end
          end
          default: seqReg <= SQ_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_RESET_QUIET: assert property ((seqReg == SQ_RESET) |-> !bitOutputStrobe && memWriteStrobeN)
    else $error("strobe active while held in reset");
  AST_RESET_TRAP: assert property ($fell(seqReg == SQ_RESET) |-> trapStrobe
    && trapVector == VEC_RESET_WP && statusWordReg == STW_RESET)
    else $error("reset release did not run the level-zero trap");
  AST_LOAD_TRAP: assert property ((seqReg == SQ_IDLE && loadPendReg && !icReset) |=>
    trapStrobe && trapVector == 16'h3ffc && statusWordReg[3:0] == 4'h0)
    else $error("load trap did not use its vector or clear the mask");
  AST_STROBE_WIDTH: assert property (disable iff (srst || icReset)
    ($rose(bitOutputStrobe) && seqReg == SQ_STROBE) |-> bitOutputStrobe[*5] ##1 !bitOutputStrobe)
    else $error("output strobe width is wrong");
  AST_BITIO_LINES: assert property ((bitOutputStrobe && opReg != OP_EXT) |->
    !addrPins.a0 && !addrPins.a1)
    else $error("lines 0 and 1 not low during bit output");
  AST_SET_VALUE: assert property ((bitOutputStrobe && opReg inside {OP_SET1, OP_SET0}) |->
    addrPins.a13 == (opReg == OP_SET1))
    else $error("set value line wrong");
  AST_INPUT_NO_STROBE: assert property ((seqReg == SQ_SETUP && opReg inside {OP_TEST, OP_FIN}
    && !tick) |=> !bitOutputStrobe && $stable(addrPins.bitAddr))
    else $error("strobe or address moved during input sampling");
  AST_TEST_COPY: assert property ((seqReg == SQ_SETUP && tick && opReg == OP_TEST && !icReset)
    |=> statusWordReg[STW_EQ_POS] == $past(bitSerialInput))
    else $error("test result not copied to equal flag");
  AST_FIELD_STEP: assert property ((seqReg == SQ_STROBE && tick && opReg == OP_FOUT
    && remainReg > 5'd1 && !icReset) |=> addrPins.bitAddr == $past(addrPins.bitAddr) + 11'h1)
    else $error("field output address did not step by one");
  AST_HALT_EXIT: assert property ((seqReg == SQ_HALT && icLoad && !icReset) |=>
    seqReg == SQ_IDLE ##1 trapStrobe)
    else $error("load did not end idle and trap");

  COV_FIELD16: cover property (seqReg == SQ_STROBE && opReg == OP_FOUT && remainReg == 5'd16);
  COV_HALT: cover property (seqReg == SQ_HALT && bitOutputStrobe);
  COV_LOAD: cover property (trapStrobe && trapVector == VEC_LOAD);
endmodule : bio_unit

//--- bio_pkg.sv
// Shared constants, types and register map for the bit I/O unit.
// What this block does
// - Up to 2,048 output bits, 11-bit address on lines 2 to 12.
// - Single bits and fields of 1 to 16 bits, both directions.
// - Set-one and set-zero pulse the strobe; line 13 carries the value.
// - Test-bit copies the sampled input bit into status equal flag.
// - Single-bit address is base bits 1-11 plus signed 8-bit displacement.
// - Field output of 8 or fewer bits from a byte, else whole word.
// - Field output shifts right, LSB first, addresses ascending by one.
// - Field input stored right-justified, zero-filled, byte or full word.
// - First received bit lands in the least significant position.
// - External instructions drive a unique 3-bit code with a strobe pulse.
// - Codes on lines 13/0/1; bit operations drive lines 0 and 1 low.
// - Idle halts until interrupt, reset or load, re-emitting code and strobe.
// - Load code traps after current operation, vector 3FFC, mask cleared.
// - Load stimulus ends the idle state.
// - While reset code is present, stay in reset with strobes inactive.
// - On reset removal, level-zero trap from 0000/0002 and clear status.
// - Reset code ends the idle state.
// - Interrupt code: 000/001 reset, 010 load, 011-110 levels, 111 none.
// - Strobe is active high; outside samples value or decodes code then.
// - Input and test operations sample the line for the addressed bit.
package bio_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_TRAP = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_EXT_LSB = 4;
  localparam int CMD_CNT_LSB = 8;
  localparam int CMD_BYTE_POS = 12;
  localparam int CMD_DISP_LSB = 16;
  localparam int STAT_BUSY = 16;
  localparam int STAT_HALT = 17;
  localparam int STAT_RESET = 18;
  localparam int STAT_LOADPEND = 19;
  localparam int STW_EQ_POS = 13;
  localparam int BASE_LSB = 1;
  localparam int BASE_MSB = 11;
  localparam logic [15:0] STW_RESET = 16'h0000;
  localparam logic [3:0] MASK_LOAD = 4'h0;
  localparam logic [15:0] VEC_LOAD = 16'h3ffc;
  localparam logic [15:0] VEC_RESET_WP = 16'h0000;
  localparam logic [15:0] VEC_RESET_PC = 16'h0002;
  localparam logic [2:0] IC_RESET0 = 3'h0;
  localparam logic [2:0] IC_RESET1 = 3'h1;
  localparam logic [2:0] IC_LOAD = 3'h2;
  localparam logic [2:0] IC_LVL1 = 3'h3;
  localparam logic [2:0] IC_LVL4 = 3'h6;
  localparam logic [2:0] IC_NONE = 3'h7;
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_PHASE_NS = 100;
  localparam int BIT_PHASE_CYC = (BIT_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_CYC = 3;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_TEST = 3'b001, OP_SET1 = 3'b010, OP_SET0 = 3'b011,
    OP_FOUT = 3'b100, OP_FIN = 3'b101, OP_EXT = 3'b110, OP_BAD = 3'b111
  } bio_op_e;
  typedef enum logic [2:0] {
    EXT_LOAD_EXEC = 3'b000, EXT_CLOCK_OFF = 3'b001, EXT_CLOCK_ON = 3'b010,
    EXT_RESET = 3'b011, EXT_IDLE = 3'b100
  } bio_ext_e;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_SETUP = 3'b001, SQ_STROBE = 3'b010,
    SQ_HALT = 3'b011, SQ_RESET = 3'b100
  } bio_state_e;
  typedef struct packed {
    logic [10:0] bitAddr;
    logic a13;
    logic a0;
    logic a1;
  } bio_pins_s;
  typedef struct packed {
    logic a13;
    logic a0;
    logic a1;
  } bio_code_s;
  localparam bio_code_s CODE_LOAD_EXEC = 3'b111;
  localparam bio_code_s CODE_CLOCK_OFF = 3'b110;
  localparam bio_code_s CODE_CLOCK_ON = 3'b101;
  localparam bio_code_s CODE_RESET = 3'b011;
  localparam bio_code_s CODE_IDLE = 3'b010;
endpackage : bio_pkg

//--- bio_tick_div.sv
// Divider that makes the one-cycle bit phase enable.
`timescale 1ns/1ps
module bio_tick_div #(
  parameter int DIV = 5
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clr,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cntReg;

  always_ff @(posedge clk) begin
    if (srst || clr) begin
      cntReg <= '0;
      tick <= 1'b0;
    end else if (cntReg == LAST) begin
      cntReg <= '0;
      tick <= 1'b1;
    end else begin
      cntReg <= cntReg + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule : bio_tick_div

//--- bio_ic_decode.sv
// Decoder of the interrupt-code inputs.
`timescale 1ns/1ps
module bio_ic_decode (
  input wire logic [2:0] code,
  input wire logic [3:0] mask,
  output logic isReset,
  output logic isLoad,
  output logic intOk
);
  import bio_pkg::*;
  logic [3:0] level;

  always_comb begin
    isReset = (code == IC_RESET0) || (code == IC_RESET1);
    isLoad = (code == IC_LOAD);
    level = {1'b0, code} - 4'h2;
    intOk = (code >= IC_LVL1) && (code <= IC_LVL4) && (level <= mask);
  end
endmodule : bio_ic_decode

//--- bio_periph_model.sv
// Far-side model: bit-addressed peripheral with external-code decode.
`timescale 1ns/1ps
module bio_periph_model (
  input wire logic clk,
  input wire bio_pkg::bio_pins_s addrPins,
  input wire logic bitOutputStrobe,
  output logic bitSerialInput
);
  import bio_pkg::*;
  logic bitStore [2048];
  logic prevStrobe = 1'b0;
  bio_code_s lastCode = 3'h0;
  int codeCount = 0;
  initial begin
    foreach (bitStore[i]) bitStore[i] = 1'b0;
  end
  // Bit writes only reach storage when lines 0 and 1 are both low.
  always @(posedge clk) begin
    prevStrobe <= bitOutputStrobe;
    if (bitOutputStrobe && !prevStrobe) begin
      if (!addrPins.a0 && !addrPins.a1) begin
        bitStore[addrPins.bitAddr] <= addrPins.a13;
      end else begin
        lastCode <= {addrPins.a13, addrPins.a0, addrPins.a1};
        codeCount <= codeCount + 1;
      end
    end
  end
  assign bitSerialInput = bitStore[addrPins.bitAddr];
endmodule : bio_periph_model

//--- bio_unit_test.sv
// Self-checking bench for the bit I/O unit driven over its register bus.
`timescale 1ns/1ps
module bio_unit_test;
  import bio_pkg::*;
  logic clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] interruptCodeInputs;
  logic bitSerialInput, bitOutputStrobe, memWriteStrobeN, fetchFlag;
  bio_pins_s addrPins;
  logic [15:0] src, got16;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int cnt0;
  int nFetch = 0;
  bio_code_s extCodes [4] = '{CODE_LOAD_EXEC, CODE_CLOCK_OFF, CODE_CLOCK_ON, CODE_RESET};
  bio_unit bio_unit_inst (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bitSerialInput, .interruptCodeInputs,
    .addrPins, .bitOutputStrobe, .instructionFetchFlag(fetchFlag), .memWriteStrobeN,
    .trapStrobe(), .trapVector());
  bio_periph_model bio_periph_model_inst (.clk, .addrPins, .bitOutputStrobe,
    .bitSerialInput);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Counts fetch pulses so that each command started through run can be matched to one pulse.
  always @(posedge clk) begin
    if (fetchFlag === 1'b1) nFetch <= nFetch + 1;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge clk);
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (s_axi_arready !== 1'b1) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  function automatic logic [31:0] cw(input int op, input int ext, input int cnt,
      input int bs, input int disp);
    return 32'(op | (ext << CMD_EXT_LSB) | (cnt << CMD_CNT_LSB) | (bs << CMD_BYTE_POS)
      | ((disp & 255) << CMD_DISP_LSB));
  endfunction : cw
  // Loads the base word, starts a command and polls until the unit is no longer busy.
  task automatic run(input logic [15:0] base, input logic [31:0] c);
    int f0;
    f0 = nFetch;
    wr(REG_BASE, {16'h0, base});
    wr(REG_CMD, c);
    rd(REG_STAT);
    for (int i = 0; i < 100 && rv[STAT_BUSY] !== 1'b0; i++) rd(REG_STAT);
    chk(rv[STAT_BUSY], 32'h0);
    chk(nFetch - f0, 32'h1);
  endtask : run
  initial begin
    srst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    interruptCodeInputs = IC_NONE;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(REG_TRAP);
    chk(rv[15:0], VEC_RESET_WP);
    src = 16'ha5c3;
    wr(REG_WDATA, {16'h0, src});
    run(16'h0100, cw(4, 0, 0, 0, 0));
    for (int i = 0; i < 16; i++) got16[i] = bio_periph_model_inst.bitStore[128 + i];
    chk(got16, src);
    run(16'h0200, cw(4, 0, 8, 0, 0));
    for (int i = 0; i < 8; i++) got16[i] = bio_periph_model_inst.bitStore[256 + i];
    chk(got16[7:0], src[15:8]);
    run(16'h0100, cw(2, 0, 0, 0, -1));
    chk(bio_periph_model_inst.bitStore[127], 1);
    run(16'h0100, cw(3, 0, 0, 0, 0));
    chk(bio_periph_model_inst.bitStore[128], 0);
    run(16'h00fe, cw(5, 0, 0, 0, 0));
    rd(REG_RDATA);
    chk(rv[15:0], {src[14:1], 2'b01});
    run(16'h0100, cw(5, 0, 5, 1, 0));
    rd(REG_RDATA);
    chk(rv[7:0], {3'h0, src[4:1], 1'b0});
    run(16'h0100, cw(5, 0, 5, 0, 0));
    rd(REG_RDATA);
    chk(rv[15:0], {2{3'h0, src[4:1], 1'b0}});
    for (int i = 0; i < 2; i++) begin
      run(16'h0100, cw(1, 0, 0, 0, i));
      rd(REG_STAT);
      chk(rv[STW_EQ_POS], 32'(i));
    end
    for (int e = 0; e < 4; e++) begin
      run(16'h0100, cw(6, e, 0, 0, 0));
      chk(bio_periph_model_inst.lastCode, extCodes[e]);
    end
    rd(8'h20);
    chk(resp, RESP_SLVERR);
    wr(REG_RDATA, 32'h1);
    chk(resp, RESP_SLVERR);
    wr(REG_STAT, 32'h000f);
    wr(REG_CMD, cw(6, 4, 0, 0, 0));
    cnt0 = bio_periph_model_inst.codeCount;
    repeat (40) @(posedge clk);
    chk(bio_periph_model_inst.lastCode, CODE_IDLE);
    chk(32'(bio_periph_model_inst.codeCount - cnt0 >= 3), 1);
    rd(REG_STAT);
    chk(rv[STAT_HALT], 1);
    interruptCodeInputs <= IC_LOAD;
    repeat (20) @(posedge clk);
    interruptCodeInputs <= IC_NONE;
    rd(REG_TRAP);
    chk(rv, {16'h000f, VEC_LOAD});
    rd(REG_STAT);
    chk({rv[STAT_HALT], rv[3:0]}, {1'b0, MASK_LOAD});
    wr(REG_STAT, 32'h8000);
    wr(REG_CMD, cw(6, 4, 0, 0, 0));
    interruptCodeInputs <= IC_RESET0;
    repeat (2) @(posedge clk);
    interruptCodeInputs <= IC_RESET1;
    rd(REG_STAT);
    chk(rv[STAT_RESET], 1);
    chk({bitOutputStrobe, memWriteStrobeN}, 2'b01);
    interruptCodeInputs <= IC_NONE;
    repeat (3) @(posedge clk);
    rd(REG_STAT);
    chk({rv[STAT_HALT], rv[15:0]}, {1'b0, STW_RESET});
    rd(REG_TRAP);
    chk(rv[15:0], VEC_RESET_WP);
    report_and_stop();
  end
endmodule : bio_unit_test
